// [hdl/addr_stepper.sv]
// Purpose: next address of a continuous transfer
// Assumes: only implemented addresses are presented
// Notes:   unused holes are jumped, the set wraps to its start
`timescale 1ns/1ps
module addr_stepper
   import afe_regmap_pkg::*;
(
   input  afe_regmap_pkg::addr_t addr,
   input  wire logic [1:0]       rd_loop,
   input  wire logic             wr_loop,
   input  wire logic             is_read,
   output afe_regmap_pkg::addr_t nxt
);
   addr_t lo;
   addr_t hi;
   addr_t inc;
   always_comb begin
      lo = addr;
      hi = addr;
      if (is_read) begin
         unique case (rd_loop)
            RD_MAP: begin
               lo = A_RES0;
               hi = A_SEC;
            end
            RD_TYPE: begin
               lo = (addr <= A_RES2) ? A_RES0 : A_MOD;
               hi = (addr <= A_RES2) ? A_RES2 : A_SEC;
            end
            RD_GROUP: begin
               if (addr <= A_RES2) begin
                  lo = A_RES0;
                  hi = A_RES2;
               end else if (addr <= A_GAIN) begin
                  lo = A_MOD;
                  hi = A_GAIN;
               end else if (addr <= A_SETUP_B) begin
                  lo = A_STATUS;
                  hi = A_SETUP_B;
               end else if (addr <= A_GTRIM0) begin
                  lo = A_OTRIM0;
                  hi = A_GTRIM0;
               end else if (addr <= A_GTRIM1) begin
                  lo = A_OTRIM1;
                  hi = A_GTRIM1;
               end else if (addr <= A_GTRIM2) begin
                  lo = A_OTRIM2;
                  hi = A_GTRIM2;
               end
            end
            RD_STATIC: begin
            end
         endcase
      end else if (wr_loop) begin
         lo = A_MOD;
         hi = A_SEC;
      end
      inc = addr + 5'h01;
      if (inc >= A_UNU_LO && inc <= A_UNU_HI) inc = A_MOD;
      if (inc == A_HOLE) inc = A_PHASE;
      if (inc >= A_GAP_LO && inc <= A_GAP_HI) inc = A_SEC;
      nxt = (addr == hi) ? lo : inc;
   end
endmodule : addr_stepper

// [hdl/afe_regmap.sv]
// Purpose: register bank of a three-channel front end behind its serial port
// Assumes: SCK well below MCLK/4, mode 0,0; command = dev addr, reg addr, read bit
// Notes:   pins pass two flops, so each SCK phase needs three MCLK at least
// How it works
// - every register is 24 bits and can be reached by a single-address access.
// - result words at 0x00 to 0x02 are shaped by the width field of status.
// - the three result registers are read-only 24-bit words sent MSB first.
// - read-loop and write-loop fields pick the set the address cycles through.
// - read loop 11 walks the map, 10 one type, 01 one group, 00 stays put.
// - write loop 1 walks the writable registers only, 0 stays put.
// - 0x08 is read/write and follows the modulator output bits.
// - 0x0a holds the phase delays; writing it restarts the converters.
// - offset and gain trims alternate per channel from 0x0f to 0x14.
// - 0x1f holds the lock byte and a CRC-16 over the configuration words 0x08 to 0x14.
// - a result word is latched when its read starts.
`timescale 1ns/1ps
module afe_regmap #(
   parameter logic [1:0] DEV_ADDR = 2'h1
) (
   // clock and reset
   input  wire logic                  MCLK,
   input  wire logic                  RST_N,
   // serial port
   input  wire logic                  SCK,
   input  wire logic                  CS_N,
   input  wire logic                  SDI,
   output logic                       SDO,
   output logic                       SDO_OE,
   // converter side
   input  afe_regmap_pkg::word_t      ADC_CH0,
   input  afe_regmap_pkg::word_t      ADC_CH1,
   input  afe_regmap_pkg::word_t      ADC_CH2,
   input  wire logic [11:0]           MOD_IN,
   input  wire logic                  MOD_STB,
   output logic                       ADC_RESTART,
   // configuration out
   output afe_regmap_pkg::word_t      PHASE_CFG,
   output afe_regmap_pkg::word_t      GAIN_CFG,
   output afe_regmap_pkg::word_t      STATUS_CFG,
   output afe_regmap_pkg::word_t      SETUP_A_CFG,
   output afe_regmap_pkg::word_t      SETUP_B_CFG,
   output afe_regmap_pkg::word_t      OFF_TRIM0,
   output afe_regmap_pkg::word_t      GAIN_TRIM0,
   output afe_regmap_pkg::word_t      OFF_TRIM1,
   output afe_regmap_pkg::word_t      GAIN_TRIM1,
   output afe_regmap_pkg::word_t      OFF_TRIM2,
   output afe_regmap_pkg::word_t      GAIN_TRIM2,
   output afe_regmap_pkg::word_t      SEC_WORD
);
   import afe_regmap_pkg::*;

   logic             sck_s, cs_n_s, sdi_s;
   logic             sck_prev_q;
   state_e           st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d, len_q, len_d;
   word_t            in_q, in_d;
   logic [SR_W-1:0]  out_q, out_d;
   addr_t            addr_q, addr_d, nxt, load_a, wr_a;
   logic             rd_q, rd_d, sdo_q, sdo_d, oe_q, oe_d, rst_q, rst_d;
   logic             rise, fall, adv, load_en, wr_en;
   logic [CMD_W-1:0] cmd;
   word_t            wr_val;
   word_t            ld_w;
   word_t            regs_q [A_MOD:A_SEC];
   word_t            regs_d [A_MOD:A_SEC];
   addr_t            cidx_q, cidx_d;
   logic [4:0]       cbit_q, cbit_d;
   logic [CRC_W-1:0] crun_q, crun_d, crc_q, crc_d;
   logic             cfb;
   logic [1:0]       rd_loop, fmt;
   logic             wr_loop;

   pin_sync #(.RST_VAL(1'b0)) u_sck (.clk(MCLK), .rst_n(RST_N), .pin(SCK), .sync(sck_s));
   pin_sync #(.RST_VAL(1'b1)) u_cs (.clk(MCLK), .rst_n(RST_N), .pin(CS_N), .sync(cs_n_s));
   pin_sync #(.RST_VAL(1'b0)) u_sdi (.clk(MCLK), .rst_n(RST_N), .pin(SDI), .sync(sdi_s));

   assign rise    = sck_s & ~sck_prev_q;
   assign fall    = ~sck_s & sck_prev_q;
   assign rd_loop = regs_q[A_STATUS][RDLOOP_LSB +: 2];
   assign wr_loop = regs_q[A_STATUS][WRLOOP_BIT];
   assign fmt     = regs_q[A_STATUS][WIDTH_LSB +: 2];

   addr_stepper u_step (
      .addr   (addr_q),
      .rd_loop(rd_loop),
      .wr_loop(wr_loop),
      .is_read(rd_q),
      .nxt    (nxt)
   );

   function automatic logic impl(input addr_t a);
      return (a <= A_RES2) || (a == A_MOD) || (a >= A_PHASE && a <= A_GTRIM2) || (a == A_SEC);
   endfunction : impl

   // result registers come straight from the converter at load time
   function automatic word_t rd_word(input addr_t a);
      word_t w;
      w = ZERO_W;
      if (a == A_RES0) w = ADC_CH0;
      else if (a == A_RES1) w = ADC_CH1;
      else if (a == A_RES2) w = ADC_CH2;
      else if (a == A_SEC) w = {regs_q[A_SEC][WORD_W-1:LOCK_LSB], crc_q};
      else if (impl(a)) w = regs_q[a];
      return w;
   endfunction : rd_word

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      len_d  = len_q;
      in_d   = in_q;
      out_d  = out_q;
      addr_d = addr_q;
      rd_d   = rd_q;
      sdo_d  = sdo_q;
      oe_d   = oe_q;
      rst_d  = 1'b0;
      regs_d = regs_q;
      adv     = 1'b0;
      load_en = 1'b0;
      load_a  = addr_q;
      wr_en   = 1'b0;
      wr_a    = addr_q;
      wr_val  = {in_q[WORD_W-2:0], sdi_s};
      ld_w    = ZERO_W;
      cmd     = {in_q[CMD_W-2:0], sdi_s};
      if (MOD_STB) regs_d[A_MOD][MOD_W-1:0] = MOD_IN;
      if (cs_n_s) begin
         st_d = S_IDLE;
         oe_d = 1'b0;
      end else begin
         unique case (st_q)
            S_IDLE: begin
               st_d  = S_CMD;
               cnt_d = '0;
            end
            S_CMD: begin
               if (rise) begin
                  in_d  = wr_val;
                  cnt_d = cnt_q + 6'h01;
                  if (cnt_q == 6'(CMD_W - 1)) begin
                     cnt_d  = '0;
                     addr_d = cmd[ADDR_W:1];
                     rd_d   = cmd[0];
                     st_d   = (cmd[CMD_W-1 -: 2] == DEV_ADDR) ? S_DATA : S_SKIP;
                     if (cmd[0] && cmd[CMD_W-1 -: 2] == DEV_ADDR) begin
                        load_en = 1'b1;
                        load_a  = cmd[ADDR_W:1];
                        oe_d    = 1'b1;
                     end
                  end
               end
            end
            S_DATA: begin
               if (rise) begin
                  cnt_d = cnt_q + 6'h01;
                  in_d  = wr_val;
                  if (rd_q && cnt_q == len_q - 6'h01) begin
                     adv     = 1'b1;
                     cnt_d   = '0;
                     addr_d  = nxt;
                     load_en = 1'b1;
                     load_a  = nxt;
                  end else if (!rd_q && cnt_q == 6'(WORD_W - 1)) begin
                     adv    = 1'b1;
                     cnt_d  = '0;
                     addr_d = nxt;
                     wr_en  = impl(addr_q) && addr_q > A_RES2;
                     wr_a   = addr_q;
                  end
               end
               if (fall && rd_q) begin
                  sdo_d = out_q[SR_W-1];
                  out_d = {out_q[SR_W-2:0], 1'b0};
               end
            end
            S_SKIP: begin
            end
         endcase
      end
      // the snapshot taken here protects the word from later conversions
      if (load_en) begin
         ld_w  = rd_word(load_a);
         len_d = LEN_24;
         out_d = {ld_w, 8'h00};
         if (load_a <= A_RES2) begin
            unique case (fmt)
               FMT_16:  len_d = LEN_16;
               FMT_24:  len_d = LEN_24;
               FMT_32Z: begin
                  len_d = LEN_32;
               end
               FMT_32S: begin
                  len_d = LEN_32;
                  out_d = {{8{ld_w[WORD_W-1]}}, ld_w};
               end
            endcase
         end
      end
      if (wr_en) begin
         if (wr_a == A_MOD) regs_d[A_MOD] = {12'h000, wr_val[MOD_W-1:0]};
         else if (wr_a == A_SEC) regs_d[A_SEC] = {wr_val[WORD_W-1:LOCK_LSB], 16'h0000};
         else regs_d[wr_a] = wr_val;
         rst_d = (wr_a == A_PHASE);
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         sck_prev_q <= 1'b0;
         st_q       <= S_IDLE;
         cnt_q      <= '0;
         len_q      <= LEN_24;
         in_q       <= ZERO_W;
         out_q      <= '0;
         addr_q     <= A_RES0;
         rd_q       <= 1'b0;
         sdo_q      <= 1'b0;
         oe_q       <= 1'b0;
         rst_q      <= 1'b0;
         for (int i = A_MOD; i <= A_SEC; i++) regs_q[i] <= ZERO_W;
         regs_q[A_MOD]    <= MOD_RST;
         regs_q[A_STATUS] <= STATUS_RST;
      end else begin
         sck_prev_q <= sck_s;
         st_q       <= st_d;
         cnt_q      <= cnt_d;
         len_q      <= len_d;
         in_q       <= in_d;
         out_q      <= out_d;
         addr_q     <= addr_d;
         rd_q       <= rd_d;
         sdo_q      <= sdo_d;
         oe_q       <= oe_d;
         rst_q      <= rst_d;
         regs_q     <= regs_d;
      end
   end

   // crc walks the configuration words one bit a clock; a pass takes 312 clocks
   always_comb begin
      cidx_d = cidx_q;
      cbit_d = cbit_q + 5'h01;
      crc_d  = crc_q;
      cfb    = crun_q[CRC_W-1] ^ regs_q[cidx_q][TOP_BIT - cbit_q];
      crun_d = {crun_q[CRC_W-2:0], 1'b0} ^ (cfb ? CRC_POLY : CRC_SEED);
      if (cbit_q == TOP_BIT) begin
         cbit_d = '0;
         cidx_d = cidx_q + 5'h01;
         if (cidx_q == A_GTRIM2) begin
            cidx_d = A_MOD;
            crc_d  = crun_d;
            crun_d = CRC_SEED;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         cidx_q <= A_MOD;
         cbit_q <= '0;
         crun_q <= CRC_SEED;
         crc_q  <= CRC_SEED;
      end else begin
         cidx_q <= cidx_d;
         cbit_q <= cbit_d;
         crun_q <= crun_d;
         crc_q  <= crc_d;
      end
   end

   assign SDO         = sdo_q;
   assign SDO_OE      = oe_q;
   assign ADC_RESTART = rst_q;
   assign PHASE_CFG   = regs_q[A_PHASE];
   assign GAIN_CFG    = regs_q[A_GAIN];
   assign STATUS_CFG  = regs_q[A_STATUS];
   assign SETUP_A_CFG = regs_q[A_SETUP_A];
   assign SETUP_B_CFG = regs_q[A_SETUP_B];
   assign OFF_TRIM0   = regs_q[A_OTRIM0];
   assign GAIN_TRIM0  = regs_q[A_GTRIM0];
   assign OFF_TRIM1   = regs_q[A_OTRIM1];
   assign GAIN_TRIM1  = regs_q[A_GTRIM1];
   assign OFF_TRIM2   = regs_q[A_OTRIM2];
   assign GAIN_TRIM2  = regs_q[A_GTRIM2];
   assign SEC_WORD    = {regs_q[A_SEC][WORD_W-1:LOCK_LSB], crc_q};

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   word_len_a: assert property (load_en && load_a > A_RES2 |=> len_q == LEN_24)
      else $error("non-result word not 24 bits");
   fmt_width_a: assert property (load_en && load_a <= A_RES2 && fmt == FMT_16 |=> len_q == LEN_16)
      else $error("16-bit result format ignored");
   result_ro_a: assert property (wr_en |-> wr_a > A_RES2 && impl(wr_a))
      else $error("write reached a read-only or unused address");
   read_loop_a: assert property (adv && rd_q && rd_loop == RD_STATIC |=> addr_q == $past(addr_q))
      else $error("static read moved the address");
   map_wrap_a: assert property (adv && rd_q && rd_loop == RD_MAP && addr_q == A_SEC |=> addr_q == A_RES0)
      else $error("map loop did not wrap");
   group_wrap_a: assert property (adv && rd_q && rd_loop == RD_GROUP && addr_q == A_SETUP_B |=> addr_q == A_STATUS)
      else $error("group loop did not wrap");
   write_loop_a: assert property (adv && !rd_q && wr_loop && addr_q == A_SEC |=> addr_q == A_MOD)
      else $error("write loop did not wrap to first writable");
   mod_track_a: assert property (MOD_STB && !wr_en |=> regs_q[A_MOD][MOD_W-1:0] == $past(MOD_IN))
      else $error("modulator bits not captured");
   phase_restart_a: assert property (wr_en && wr_a == A_PHASE |=> ADC_RESTART ##1 !ADC_RESTART)
      else $error("phase write gave no single restart pulse");
   trim_write_a: assert property (wr_en && wr_a == A_OTRIM1 |=> OFF_TRIM1 == $past(wr_val))
      else $error("trim write lost");
   crc_read_a: assert property (load_en && load_a == A_SEC |=> out_q[SR_W-9 -: CRC_W] == $past(crc_q))
      else $error("security word lacks checksum");
   latch_a: assert property (load_en && load_a == A_RES1 && fmt == FMT_24 |=> out_q[SR_W-1 -: WORD_W] == $past(ADC_CH1))
      else $error("result not latched at read start");
   skip_unused_a: assert property (adv |-> impl(nxt))
      else $error("loop landed on unused address");

   map_read_c: cover property (adv && rd_q && rd_loop == RD_MAP && addr_q == A_SEC);
   wr_loop_c: cover property (adv && !rd_q && wr_loop && addr_q == A_SEC);
   res32_c: cover property (load_en && load_a == A_RES0 && fmt == FMT_32S);
   restart_c: cover property (ADC_RESTART);
endmodule : afe_regmap

// [hdl/afe_regmap_pkg.sv]
// Purpose: shared constants of the front-end register bank
// Assumes: 5-bit register addresses, 24-bit registers
// Notes:   status field positions and reset values are local picks
package afe_regmap_pkg;
   localparam int ADDR_W = 5;
   localparam int WORD_W = 24;
   localparam int SR_W   = 32;
   localparam int CMD_W  = 8;
   localparam int CNT_W  = 6;
   localparam int MOD_W  = 12;
   localparam int CRC_W  = 16;
   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [WORD_W-1:0] word_t;
   // register addresses
   localparam addr_t A_RES0    = 5'h00;
   localparam addr_t A_RES1    = 5'h01;
   localparam addr_t A_RES2    = 5'h02;
   localparam addr_t A_UNU_LO  = 5'h03;
   localparam addr_t A_UNU_HI  = 5'h07;
   localparam addr_t A_MOD     = 5'h08;
   localparam addr_t A_HOLE    = 5'h09;
   localparam addr_t A_PHASE   = 5'h0a;
   localparam addr_t A_GAIN    = 5'h0b;
   localparam addr_t A_STATUS  = 5'h0c;
   localparam addr_t A_SETUP_A = 5'h0d;
   localparam addr_t A_SETUP_B = 5'h0e;
   localparam addr_t A_OTRIM0  = 5'h0f;
   localparam addr_t A_GTRIM0  = 5'h10;
   localparam addr_t A_OTRIM1  = 5'h11;
   localparam addr_t A_GTRIM1  = 5'h12;
   localparam addr_t A_OTRIM2  = 5'h13;
   localparam addr_t A_GTRIM2  = 5'h14;
   localparam addr_t A_GAP_LO  = 5'h15;
   localparam addr_t A_GAP_HI  = 5'h1e;
   localparam addr_t A_SEC     = 5'h1f;
   // status/communication fields
   localparam int RDLOOP_LSB = 22;
   localparam int WRLOOP_BIT = 21;
   localparam int WIDTH_LSB  = 19;
   localparam int LOCK_LSB   = 16;
   localparam logic [1:0] RD_STATIC = 2'h0;
   localparam logic [1:0] RD_GROUP  = 2'h1;
   localparam logic [1:0] RD_TYPE   = 2'h2;
   localparam logic [1:0] RD_MAP    = 2'h3;
   localparam logic [1:0] FMT_16    = 2'h0;
   localparam logic [1:0] FMT_24    = 2'h1;
   localparam logic [1:0] FMT_32Z   = 2'h2;
   localparam logic [1:0] FMT_32S   = 2'h3;
   // reset values
   localparam word_t STATUS_RST = 24'ha80000;
   localparam word_t MOD_RST    = 24'h000333;
   localparam word_t ZERO_W     = 24'h000000;
   localparam logic [CRC_W-1:0] CRC_POLY = 16'h8005;
   localparam logic [CRC_W-1:0] CRC_SEED = 16'h0000;
   localparam logic [4:0] TOP_BIT = 5'h17;
   localparam logic [CNT_W-1:0] LEN_16 = 6'h10;
   localparam logic [CNT_W-1:0] LEN_24 = 6'h18;
   localparam logic [CNT_W-1:0] LEN_32 = 6'h20;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_CMD  = 2'b01,
      S_DATA = 2'b11,
      S_SKIP = 2'b10
   } state_e;
endpackage : afe_regmap_pkg

// [hdl/pin_sync.sv]
// Purpose: two-flop synchroniser for one pin
// Assumes: pin is asynchronous to MCLK
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      sync
);
   logic meta_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         sync   <= RST_VAL;
      end else begin
         meta_q <= pin;
         sync   <= meta_q;
      end
   end
endmodule : pin_sync

// [verif/spi_host_model.sv]
// Purpose: host end of the serial port; drives SCK, CS_N and SDI and samples SDO
// Assumes: mode 0,0; every SCK phase lasts 6 MCLK so the device pin sync keeps up
// Notes:   SDO is sampled half a cycle before each rise, well after the device moved it
`timescale 1ns/1ps
module spi_host_model (
   // clock
   input  wire logic mclk,
   // serial port
   output logic      sck,
   output logic      cs_n,
   output logic      sdi,
   input  wire logic sdo,
   input  wire logic sdo_oe
);
   initial begin
      sck  = 1'b0;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end

   task automatic open_frame();
      cs_n <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : open_frame

   // msb first in both directions, n bits of wd out, n bits into rd
   task automatic shift(input int n, input logic [31:0] wd, output logic [31:0] rd);
      rd = 32'h0;
      for (int i = n - 1; i >= 0; i--) begin
         sdi <= wd[i];
         repeat (5) @(posedge mclk);
         @(negedge mclk);
         // an undriven line reads as the inverse of its last bit
         rd = {rd[30:0], sdo_oe ? sdo : ~sdo};
         @(posedge mclk);
         sck <= 1'b1;
         repeat (6) @(posedge mclk);
         sck <= 1'b0;
      end
   endtask : shift

   // sdi flips on release so a stale bit never reads as valid
   task automatic close_frame();
      repeat (4) @(posedge mclk);
      cs_n <= 1'b1;
      sdi  <= ~sdi;
      repeat (6) @(posedge mclk);
   endtask : close_frame
endmodule : spi_host_model

// [verif/test_afe_regmap.sv]
// Purpose: self-checking bench of the register bank through its serial port
// Assumes: device address 1, expected words kept in a local shadow table
// Notes:   crc is predicted from the shadow table once the registers are quiet
`timescale 1ns/1ps
module test_afe_regmap;
   import afe_regmap_pkg::*;
   localparam logic [1:0] DEV = 2'h1;
   logic        mclk, rst_n, sck, cs_n, sdi, sdo, sdo_oe, mod_stb, restart;
   logic [11:0] mod_in;
   word_t       ch0, ch1, ch2, phase, gain, status, set_a, set_b, sec;
   word_t       ot0, gt0, ot1, gt1, ot2, gt2;
   int          error_cnt, checks_done, n_restart;
   logic [31:0] got [3];
   word_t       shadow [32];
   addr_t       rw_a [10] = '{5'h0a, 5'h0b, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12,
                              5'h13, 5'h14};
   addr_t       un_a [4] = '{5'h05, 5'h09, 5'h15, 5'h1e};
   logic [1:0]  lm [4] = '{RD_MAP, RD_TYPE, RD_GROUP, RD_STATIC};
   addr_t       seq [4][3] = '{'{5'h1f, 5'h00, 5'h01}, '{5'h02, 5'h00, 5'h01},
                               '{5'h0e, 5'h0c, 5'h0d}, '{5'h0b, 5'h0b, 5'h0b}};

   afe_regmap #(.DEV_ADDR(DEV)) i_afe_regmap (
      .MCLK(mclk), .RST_N(rst_n), .SCK(sck), .CS_N(cs_n), .SDI(sdi), .SDO(sdo),
      .SDO_OE(sdo_oe), .ADC_CH0(ch0), .ADC_CH1(ch1), .ADC_CH2(ch2), .MOD_IN(mod_in),
      .MOD_STB(mod_stb), .ADC_RESTART(restart), .PHASE_CFG(phase), .GAIN_CFG(gain),
      .STATUS_CFG(status), .SETUP_A_CFG(set_a), .SETUP_B_CFG(set_b), .OFF_TRIM0(ot0),
      .GAIN_TRIM0(gt0), .OFF_TRIM1(ot1), .GAIN_TRIM1(gt1), .OFF_TRIM2(ot2),
      .GAIN_TRIM2(gt2), .SEC_WORD(sec));

   spi_host_model i_spi_host_model (
      .mclk(mclk), .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   always @(negedge mclk) begin
      if (restart === 1'b1) n_restart++;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // one frame: command then k words of n bits, w0 first and w1 after
   task automatic xfer(input addr_t a, input logic rd, input int n, input int k,
                       input logic [31:0] w0, input logic [31:0] w1);
      logic [31:0] cmd_echo;
      i_spi_host_model.open_frame();
      i_spi_host_model.shift(8, {24'h0, DEV, a, rd}, cmd_echo);
      for (int i = 0; i < k; i++)
         i_spi_host_model.shift(n, (i == 0) ? w0 : w1, got[i]);
      i_spi_host_model.close_frame();
   endtask : xfer

   task automatic wr(input addr_t a, input word_t d);
      xfer(a, 1'b0, 24, 1, {8'h0, d}, 32'h0);
   endtask : wr

   task automatic rd_chk(input string what, input addr_t a, input word_t exp);
      xfer(a, 1'b1, 24, 1, 32'h0, 32'h0);
      chk(what, {8'h0, exp}, got[0]);
   endtask : rd_chk

   function automatic word_t st(input logic [1:0] rl, input logic wl, input logic [1:0] w);
      return {rl, wl, w, 19'h0};
   endfunction : st

   function automatic logic [31:0] fmt(input logic [1:0] w, input word_t d);
      case (w)
         FMT_16:  return {16'h0, d[23:8]};
         FMT_24:  return {8'h0, d};
         FMT_32Z: return {d, 8'h0};
         default: return {{8{d[23]}}, d};
      endcase
   endfunction : fmt

   // hole at 0x09 stays zero in the shadow, as it does in the device
   function automatic logic [CRC_W-1:0] crc_of();
      logic [CRC_W-1:0] c;
      logic             fb;
      c = CRC_SEED;
      for (int a = A_MOD; a <= A_GTRIM2; a++) begin
         for (int b = WORD_W - 1; b >= 0; b--) begin
            fb = c[CRC_W-1] ^ shadow[a][b];
            c  = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_SEED);
         end
      end
      return c;
   endfunction : crc_of

   initial begin
      repeat (90000) @(posedge mclk);
      error_cnt++;
      end_sim();
   end

   initial begin
      rst_n = 1'b0;
      mod_stb = 1'b0;
      mod_in = 12'h0;
      ch0 = 24'h812345;
      ch1 = 24'h0a0b0c;
      ch2 = 24'h7fedcb;
      error_cnt = 0;
      checks_done = 0;
      n_restart = 0;
      foreach (shadow[i]) shadow[i] = ZERO_W;
      shadow[0] = ch0;
      shadow[1] = ch1;
      shadow[2] = ch2;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("idle oe", 32'h0, {31'h0, sdo_oe});
      rd_chk("status reset", A_STATUS, STATUS_RST);
      rd_chk("mod reset", A_MOD, MOD_RST);
      foreach (rw_a[i]) begin
         shadow[rw_a[i]] = {3'b101, rw_a[i], 16'h5aa5};
         wr(rw_a[i], shadow[rw_a[i]]);
      end
      foreach (rw_a[i]) rd_chk("rw readback", rw_a[i], shadow[rw_a[i]]);
      chk("phase port", {8'h0, shadow[5'h0a]}, {8'h0, phase});
      chk("restart pulses", 32'h1, n_restart);
      chk("trim ports", {shadow[5'h0f][23:8], shadow[5'h14][15:0]},
          {ot0[23:8], gt2[15:0]});
      chk("setup ports", {shadow[5'h0b][23:16], shadow[5'h0d][23:16], shadow[5'h0e][15:0]},
          {gain[23:16], set_a[23:16], set_b[15:0]});
      chk("trim ports b", {shadow[5'h10][23:16], shadow[5'h11][23:16], shadow[5'h12][15:0]},
          {gt0[23:16], ot1[23:16], gt1[15:0]});
      wr(A_RES0, 24'h0f0f0f);
      rd_chk("result read only", A_RES0, ch0);
      foreach (un_a[i]) begin
         wr(un_a[i], 24'hffffff);
         rd_chk("unused reads zero", un_a[i], ZERO_W);
      end
      @(posedge mclk);
      mod_in <= 12'habc;
      mod_stb <= 1'b1;
      @(posedge mclk);
      mod_stb <= 1'b0;
      shadow[8] = 24'h000abc;
      rd_chk("mod capture", A_MOD, shadow[8]);
      wr(A_SEC, 24'hab1234);
      xfer(A_SEC, 1'b1, 24, 1, 32'h0, 32'h0);
      chk("lock byte", 32'hab, {24'h0, got[0][23:16]});
      for (int w = 0; w < 4; w++) begin
         wr(A_STATUS, st(RD_STATIC, 1'b0, w[1:0]));
         xfer(A_RES0, 1'b1, (w == 0) ? 16 : (w == 1) ? 24 : 32, 1, 32'h0, 32'h0);
         chk("result width", fmt(w[1:0], ch0), got[0]);
      end
      wr(A_STATUS, st(RD_STATIC, 1'b0, FMT_24));
      // data changes mid-word, the word already loaded must stay whole
      i_spi_host_model.open_frame();
      i_spi_host_model.shift(8, {24'h0, DEV, A_RES0, 1'b1}, got[0]);
      i_spi_host_model.shift(6, 32'h0, got[1]);
      ch0 <= 24'h00ffee;
      i_spi_host_model.shift(18, 32'h0, got[2]);
      i_spi_host_model.close_frame();
      chk("latched result", {8'h0, shadow[0]}, {8'h0, got[1][5:0], got[2][17:0]});
      shadow[0] = 24'h00ffee;
      for (int m = 0; m < 4; m++) begin
         shadow[A_STATUS] = st(lm[m], 1'b0, FMT_24);
         shadow[A_SEC] = {8'hab, crc_of()};
         wr(A_STATUS, shadow[A_STATUS]);
         // two full checksum passes so the word read from 0x1f is settled
         repeat (700) @(posedge mclk);
         xfer(seq[m][0], 1'b1, 24, 3, 32'h0, 32'h0);
         for (int j = 0; j < 3; j++)
            chk("read loop word", {8'h0, shadow[seq[m][j]]}, got[j]);
      end
      wr(A_STATUS, st(RD_STATIC, 1'b1, FMT_24));
      xfer(A_GTRIM2, 1'b0, 24, 2, 32'h111111, 32'h22aa33);
      chk("write loop words", 32'h11111122, {gt2, sec[23:16]});
      wr(A_STATUS, st(RD_STATIC, 1'b0, FMT_24));
      xfer(A_OTRIM2, 1'b0, 24, 2, 32'h444444, 32'h555555);
      chk("static write", 32'h55555511, {ot2, gt2[7:0]});
      i_spi_host_model.open_frame();
      i_spi_host_model.shift(8, {24'h0, ~DEV, A_GAIN, 1'b0}, got[0]);
      i_spi_host_model.shift(24, 32'h123456, got[1]);
      i_spi_host_model.close_frame();
      chk("foreign write", {8'h0, shadow[A_GAIN]}, {8'h0, gain});
      shadow[A_STATUS] = st(RD_STATIC, 1'b0, FMT_24);
      shadow[A_OTRIM2] = 24'h555555;
      shadow[A_GTRIM2] = 24'h111111;
      repeat (700) @(posedge mclk);
      chk("status port", {8'h0, shadow[A_STATUS]}, {8'h0, status});
      chk("crc word", {16'h0, crc_of()}, {16'h0, sec[15:0]});
      end_sim();
   end
endmodule : test_afe_regmap
